/* imc_mode_ctrl.sv */
// Mode control register for interrupt sources 28 to 31 on Avalon-MM
`timescale 1ns/1ps
module imc_mode_ctrl (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [31:0] avsAddress,
	input  wire logic        avsRead,
	input  wire logic        avsWrite,
	input  wire logic [31:0] avsWritedata,
	input  wire logic [3:0]  avsByteenable,
	output logic      [31:0] avsReaddata,
	output logic             avsWaitrequest,
	// Request pins: capture, compare 0, 1, 2 (sources 28..31)
	input  wire logic [3:0]  srcReq,
	// Interrupt side, one per source
	output logic      [3:0]  irqReq,
	output logic      [11:0] irqLevel,
	// DMA side, one per source
	output logic      [3:0]  dmaReq,
	output logic      [11:0] dmaChan,
	// Trigger mode view, one two-bit field per source
	output logic      [7:0]  trigMode
);
	localparam int N = imc_pkg::IMC_NUM_SRC;

	logic [N-1:0]  sync1_q;
	logic [N-1:0]  sync2_q;
	logic          hit;
	logic          done_q;
	logic [31:0]   regView;
	logic [N-1:0]  irqP;
	logic [N-1:0]  dmaP;
	logic [3*N-1:0] irqL;
	logic [3*N-1:0] dma_unit;
	logic [2*N-1:0] trigW;

	//--------------------------------------------------------------------
	// Bus slave: one wait cycle, then done for one cycle
	//--------------------------------------------------------------------
	assign hit = (avsAddress == imc_pkg::IMC_ADDR_MODE);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= (avsRead | avsWrite) & ~done_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avsWaitrequest <= 1'b1;
		end else begin
			avsWaitrequest <= ~((avsRead | avsWrite) & ~done_q);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avsReaddata <= imc_pkg::IMC_UNMAPPED;
		end else if (avsRead & ~done_q) begin
			avsReaddata <= hit ? regView : imc_pkg::IMC_UNMAPPED;
		end
	end

	//--------------------------------------------------------------------
	// Pin synchronisers
	//--------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= srcReq;
			sync2_q <= sync1_q;
		end
	end

	//--------------------------------------------------------------------
	// Per-source byte lane: byte i serves source 28+i
	//--------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_src
			logic [7:0] rdB;
			logic [1:0] tm;
			logic       rt;
			logic [2:0] lc;
			// Write lands at the end of the wait cycle, one edge before the transfer is accepted
			imc_src_cfg u_cfg (
				.clk       (clk),
				.rst       (rst),
				.wrEn      (avsWrite & ~done_q & hit &
					avsByteenable[i]),
				.wrData    (avsWritedata[8*i +: 8]),
				.rdByte    (rdB),
				.trigMode  (tm),
				.dmaRoute  (rt),
				.levelChan (lc)
			);
			imc_req_route u_route (
				.clk       (clk),
				.rst       (rst),
				.reqLevel  (sync2_q[i]),
				.dmaRoute  (rt),
				.levelChan (lc),
				.irqPulse  (irqP[i]),
				.irqLevel  (irqL[3*i +: 3]),
				.dmaPulse  (dmaP[i]),
				.dmaChan   (dma_unit[3*i +: 3])
			);
			assign regView[8*i +: 8] = rdB;
			assign trigW[2*i +: 2]   = tm;
		end
	endgenerate

	//--------------------------------------------------------------------
	// Registered outputs
	//--------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqReq   <= '0;
			irqLevel <= '0;
			dmaReq   <= '0;
			dmaChan  <= '0;
			trigMode <= '0;
		end else begin
			irqReq   <= irqP;
			irqLevel <= irqL;
			dmaReq   <= dmaP;
			dmaChan  <= dma_unit;
			trigMode <= trigW;
		end
	end

	a_wait_one: assert property (@(posedge clk) disable iff (rst)
		((avsRead || avsWrite) && avsWaitrequest && !done_q)
			|=> !avsWaitrequest)
		else $error("bus answer late");
	a_write_lane0: assert property (@(posedge clk) disable iff (rst)
		(avsWrite && !done_q && hit && avsByteenable[0]) |=>
			(regView[7:0] == ($past(avsWritedata[7:0]) & 8'h77)))
		else $error("byte 0 not written");
	a_write_lane3: assert property (@(posedge clk) disable iff (rst)
		(avsWrite && !done_q && hit && avsByteenable[3]) |=>
			(regView[31:24] == ($past(avsWritedata[31:24]) & 8'h77)))
		else $error("byte 3 not written");
	a_reserved_read: assert property (@(posedge clk) disable iff (rst)
		(avsReaddata & 32'h88888888) == 32'h0)
		else $error("reserved bits read nonzero");
endmodule

/* imc_pkg.sv */
// Package: register map, field layout and resets of the mode control block
//------------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------------
// Functional notes
// - Route clear: level code 000 masks, 001 to 111 give priority 1 to 7.
// - Route set: source is a DMA trigger, level field picks channel 0 to 7.
// - Byte 0, bits 7 to 0, configures source 28, the timer capture event.
// - Byte 1, bits 15 to 8, configures source 29, first compare match.
// - Byte 2, bits 23 to 16, configures source 30, second compare match.
// - Byte 3, bits 31 to 24, configures source 31, third compare match.
package imc_pkg;
	localparam logic [31:0] IMC_ADDR_MODE  = 32'hffffe01c;
	localparam int          IMC_NUM_SRC    = 4;
	localparam int          IMC_FIRST_SRC  = 28;
	localparam int          IMC_LVL_LSB    = 0;
	localparam int          IMC_ROUTE_BIT  = 4;
	localparam int          IMC_TRIG_LSB   = 5;
	localparam logic [7:0]  IMC_BYTE_MASK  = 8'h77;
	localparam logic [7:0]  IMC_BYTE_RESET = 8'h00;
	localparam logic [1:0]  IMC_TRIG_RISE  = 2'h3;
	localparam logic [2:0]  IMC_LVL_MASKED = 3'h0;
	localparam logic [31:0] IMC_UNMAPPED   = 32'h00000000;
endpackage

/* imc_src_cfg.sv */
// One source byte of the mode register and its decoded routing
`timescale 1ns/1ps
module imc_src_cfg (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Register access
	input  wire logic       wrEn,
	input  wire logic [7:0] wrData,
	output logic      [7:0] rdByte,
	// Decoded configuration
	output logic      [1:0] trigMode,
	output logic            dmaRoute,
	output logic      [2:0] levelChan
);
	logic [7:0] cfg_q;

	//--------------------------------------------------------------------
	// Storage
	//--------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q <= imc_pkg::IMC_BYTE_RESET;
		end else if (wrEn) begin
			cfg_q <= wrData & imc_pkg::IMC_BYTE_MASK;
		end
	end

	assign rdByte    = cfg_q;
	assign trigMode  = cfg_q[imc_pkg::IMC_TRIG_LSB +: 2];
	assign dmaRoute  = cfg_q[imc_pkg::IMC_ROUTE_BIT];
	assign levelChan = cfg_q[imc_pkg::IMC_LVL_LSB +: 3];

	a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		(cfg_q[7] == 1'b0) && (cfg_q[3] == 1'b0))
		else $error("reserved bit set");
endmodule

/* imc_req_route.sv */
// Steers one edge-detected request to interrupt or DMA trigger
`timescale 1ns/1ps
module imc_req_route (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Synchronised request level and configuration
	input  wire logic       reqLevel,
	input  wire logic       dmaRoute,
	input  wire logic [2:0] levelChan,
	// Routed outputs
	output logic            irqPulse,
	output logic      [2:0] irqLevel,
	output logic            dmaPulse,
	output logic      [2:0] dmaChan
);
	logic prev_q;
	logic rise;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= reqLevel;
		end
	end

	// Rising edge only; the trigger field is required to select it, but it is not an input here and any value gives rising edge
	assign rise = reqLevel & ~prev_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqPulse <= 1'b0;
			irqLevel <= 3'h0;
			dmaPulse <= 1'b0;
			dmaChan  <= 3'h0;
		end else begin
			irqPulse <= rise & ~dmaRoute &
				(levelChan != imc_pkg::IMC_LVL_MASKED);
			irqLevel <= dmaRoute ? 3'h0 : levelChan;
			dmaPulse <= rise & dmaRoute;
			dmaChan  <= dmaRoute ? levelChan : 3'h0;
		end
	end

	a_masked_quiet: assert property (@(posedge clk) disable iff (rst)
		(!dmaRoute && levelChan == 3'h0 && $stable(levelChan)
			&& $stable(dmaRoute)) |=> !irqPulse)
		else $error("masked source raised interrupt");
	a_dma_excl: assert property (@(posedge clk) disable iff (rst)
		!(irqPulse && dmaPulse))
		else $error("request sent to both targets");
	a_dma_route: assert property (@(posedge clk) disable iff (rst)
		(reqLevel && !prev_q && dmaRoute) |=> (dmaPulse && dmaChan ==
			$past(levelChan)))
		else $error("dma trigger missing");
	a_irq_route: assert property (@(posedge clk) disable iff (rst)
		(reqLevel && !prev_q && !dmaRoute && levelChan != 3'h0)
			|=> (irqPulse && irqLevel == $past(levelChan)))
		else $error("interrupt missing");
endmodule

/* imc_src_model.sv */
// Request source model: holds a request pin high a few cycles per fire
`timescale 1ns/1ps
module imc_src_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Fire command and request pins
	input  wire logic [3:0] fire,
	output logic      [3:0] srcReq
);
	logic [2:0] hold_q [4];
	always_ff @(posedge clk or posedge rst) begin
		for (int i = 0; i < 4; i++) begin
			if (rst)
				hold_q[i] <= 3'h0;
			else if (fire[i])
				hold_q[i] <= 3'h4;
			else if (hold_q[i] != 3'h0)
				hold_q[i] <= hold_q[i] - 3'h1;
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++)
			srcReq[i] = (hold_q[i] != 3'h0);
	end
endmodule

/* testbench.sv */
// Self-checking bench for the source 28 to 31 mode register
`timescale 1ns/1ps
module testbench;
	logic        clk, rst, avsRead, avsWrite, avsWaitrequest;
	logic [31:0] avsAddress, avsWritedata, avsReaddata, rdQ, regM, d;
	logic [3:0]  avsByteenable, fire, srcReq, irqReq, dmaReq, gI, gD;
	logic [11:0] irqLevel, dmaChan;
	logic [7:0]  trigMode;
	logic [2:0]  lv;
	integer      seed;
	int          err_total, num_checks;
	localparam logic [31:0] A = imc_pkg::IMC_ADDR_MODE;
	imc_mode_ctrl imc_mode_ctrl_i (.clk(clk), .rst(rst),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
		.avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
		.srcReq(srcReq), .irqReq(irqReq), .irqLevel(irqLevel),
		.dmaReq(dmaReq), .dmaChan(dmaChan), .trigMode(trigMode));
	imc_src_model imc_src_model_i (.clk(clk), .rst(rst), .fire(fire),
		.srcReq(srcReq));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ------------------
	// Shared tasks
	// ------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] dt,
		input logic [3:0] be);
		int n;
		n = 0;
		avsAddress    <= a;
		avsWritedata  <= dt;
		avsByteenable <= be;
		avsWrite      <= w;
		avsRead       <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (avsWaitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			err_total++;
		rdQ = avsReaddata;
		avsWrite <= 1'b0;
		avsRead  <= 1'b0;
		for (int i = 0; i < 4; i++)
			if (w && a == A && be[i])
				regM[8*i+:8] = dt[8*i+:8] & imc_pkg::IMC_BYTE_MASK;
		@(posedge clk);
	endtask
	task results;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results;
	end
	// ------------------
	// Main sequence
	// ------------------
	initial begin
		seed = 32'h8cd5a354;
		rst = 1'b1;
		{avsRead, avsWrite, avsAddress, avsWritedata} = '0;
		avsByteenable = 4'h0;
		fire = 4'h0;
		regM = '0;
		err_total = 0;
		num_checks = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, A, '0, 4'hf);
		chk(rdQ, 32'h0);
		repeat (20) begin
			d = $random(seed) | 32'h60606060;
			bus(1'b1, A, d, 4'($random(seed)));
			bus(1'b0, A, '0, 4'hf);
			chk(rdQ, regM);
			chk({regM[30:29], regM[22:21], regM[14:13], regM[6:5]},
				trigMode);
		end
		bus(1'b1, A + 32'h4, 32'hffffffff, 4'hf);
		bus(1'b0, A + 32'h4, '0, 4'hf);
		chk(rdQ, 32'h0);
		bus(1'b0, A, '0, 4'hf);
		chk(rdQ, regM);
		for (int s = 0; s < 4; s++) begin
			for (int c = 0; c < 16; c++) begin
				d = 32'h60606060 | ((((c & 8) << 1) | (c & 7)) << (8 * s));
				bus(1'b1, A, d, 4'hf);
				fire <= 4'(1 << s);
				@(posedge clk);
				fire <= 4'h0;
				{gI, gD, lv} = '0;
				repeat (12) begin
					@(negedge clk);
					gI = gI | irqReq;
					gD = gD | dmaReq;
					if (irqReq[s])
						lv = irqLevel[3*s+:3];
					if (dmaReq[s])
						lv = dmaChan[3*s+:3];
				end
				@(posedge clk);
				chk(gI, (c < 8 && c > 0) ? 1 << s : 0);
				chk(gD, c > 7 ? 1 << s : 0);
				chk(lv, c & 7);
			end
		end
		results;
	end
endmodule
